// ===== src/ilc_line_ctrl.sv
// Line level control, transfer mode and a small bit engine behind Avalon-MM
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module ilc_line_ctrl #(
    parameter int HALF = ilc_pkg::HALF_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_out,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out
);
    localparam int WAIT_CYC = ilc_pkg::WAIT_XFER_CLOCKS * 2 * HALF;

    if (HALF < 2 || WAIT_CYC > 65535) begin : g_bad_half
        $error("HALF out of range for the 16-bit phase counter");
    end

    typedef struct packed {
        ilc_pkg::ilc_state_e st;
        logic [15:0]         cnt;
        logic [3:0]          bitn;
        logic [7:0]          sh;
        logic                level;
        logic                ctrl_rst;
        logic                order;
        logic                wait_en;
        logic                master;
        logic                sync_fmt;
        logic                nack;
        logic                scl_drv;
        logic                sda_oe;
        logic                wreq;
        logic [31:0]         rdata;
    } ilc_regs_s;

    logic      rstn;
    ilc_regs_s r;
    ilc_regs_s next_r;
    logic      take_wr;
    logic      start;
    logic      out_bit;
    logic      wait_applies;
    logic [7:0] line_rd;

    ilc_reset_sync u_rst (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .rstn_out (rstn)
    );

    // Clock pin level is not read: the engine owns the timing and follows no stretching
    assign take_wr      = avs_write_in && !r.wreq && avs_byteenable_in[0];
    assign start        = take_wr && avs_address_in == ilc_pkg::OFS_DATA && r.master
                          && !r.ctrl_rst && r.st == ilc_pkg::ILC_IDLE;
    assign out_bit      = r.order ? r.sh[0] : r.sh[7];
    assign wait_applies = r.wait_en && r.master && !r.sync_fmt;

    always_comb begin
        line_rd                       = 8'h00;
        line_rd[ilc_pkg::LC_ADDR_IDLE] = 1'b0;
        line_rd[ilc_pkg::LC_SCP]      = 1'b1;
        line_rd[ilc_pkg::LC_LEVEL]    = r.level;
        line_rd[ilc_pkg::LC_WP]       = 1'b1;
        line_rd[ilc_pkg::LC_SCL_MON]  = !r.scl_drv;
        line_rd[ilc_pkg::LC_RSV2]     = 1'b1;
        line_rd[ilc_pkg::LC_CTRL_RST] = r.ctrl_rst;
        line_rd[ilc_pkg::LC_RSV0]     = 1'b1;
    end

    always_comb begin
        next_r      = r;
        next_r.wreq = 1'b1;
        // One wait cycle per access: the answer is latched on the same edge that waitrequest drops
        if ((avs_read_in || avs_write_in) && r.wreq) begin
            next_r.wreq = 1'b0;
            if (avs_read_in) begin
                next_r.rdata = 32'h0000_0000;
                if (avs_address_in == ilc_pkg::OFS_LINE) begin
                    next_r.rdata[7:0] = line_rd;
                end else if (avs_address_in == ilc_pkg::OFS_MODE) begin
                    next_r.rdata[ilc_pkg::MD_ORDER]    = r.order;
                    next_r.rdata[ilc_pkg::MD_WAIT]     = r.wait_en;
                    next_r.rdata[ilc_pkg::MD_MASTER]   = r.master;
                    next_r.rdata[ilc_pkg::MD_SYNC_FMT] = r.sync_fmt;
                end else if (avs_address_in == ilc_pkg::OFS_DATA) begin
                    next_r.rdata[7:0] = r.sh;
                end else if (avs_address_in == ilc_pkg::OFS_STATUS) begin
                    next_r.rdata[ilc_pkg::ST_BUSY] = r.st != ilc_pkg::ILC_IDLE;
                    next_r.rdata[ilc_pkg::ST_NACK] = r.nack;
                end
            end
        end
        if (take_wr) begin
            if (avs_address_in == ilc_pkg::OFS_LINE) begin
                if (!avs_writedata_in[ilc_pkg::LC_WP]) begin
                    next_r.level = avs_writedata_in[ilc_pkg::LC_LEVEL];
                end
                next_r.ctrl_rst = avs_writedata_in[ilc_pkg::LC_CTRL_RST];
            end else if (avs_address_in == ilc_pkg::OFS_MODE) begin
                next_r.order    = avs_writedata_in[ilc_pkg::MD_ORDER];
                next_r.wait_en  = avs_writedata_in[ilc_pkg::MD_WAIT];
                next_r.master   = avs_writedata_in[ilc_pkg::MD_MASTER];
                next_r.sync_fmt = avs_writedata_in[ilc_pkg::MD_SYNC_FMT];
            end
        end
        case (r.st)
            ilc_pkg::ILC_IDLE: begin
                next_r.scl_drv = 1'b0;
                next_r.sda_oe  = !r.level;
                if (start) begin
                    next_r.sh      = avs_writedata_in[7:0];
                    next_r.bitn    = 4'h0;
                    next_r.cnt     = 16'h0000;
                    next_r.nack    = 1'b0;
                    next_r.scl_drv = 1'b1;
                    next_r.st      = ilc_pkg::ILC_LOW;
                end
            end
            ilc_pkg::ILC_LOW: begin
                // Receiver owns the data line during the ack bit
                next_r.sda_oe = (r.bitn == 4'(ilc_pkg::ACK_BIT)) ? 1'b0 : !out_bit;
                next_r.cnt    = r.cnt + 16'h0001;
                if (r.cnt == 16'(HALF - 1)) begin
                    next_r.cnt     = 16'h0000;
                    next_r.scl_drv = 1'b0;
                    next_r.st      = ilc_pkg::ILC_HIGH;
                end
            end
            ilc_pkg::ILC_HIGH: begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt == 16'(HALF - 1)) begin
                    next_r.cnt     = 16'h0000;
                    next_r.scl_drv = 1'b1;
                    next_r.bitn    = r.bitn + 4'h1;
                    if (r.bitn == 4'(ilc_pkg::ACK_BIT)) begin
                        // Frame ends with the clock released, no stray pulse after ack
                        next_r.scl_drv = 1'b0;
                        next_r.nack = sda_in;
                        next_r.st   = ilc_pkg::ILC_IDLE;
                    end else begin
                        next_r.sh = r.order ? {sda_in, r.sh[7:1]} : {r.sh[6:0], sda_in};
                        if (r.bitn != 4'(ilc_pkg::LAST_DATA_BIT)) begin
                            next_r.st = ilc_pkg::ILC_LOW;
                        end else if (r.sync_fmt) begin
                            next_r.scl_drv = 1'b0;
                            next_r.st = ilc_pkg::ILC_IDLE;
                        end else if (wait_applies) begin
                            next_r.st = ilc_pkg::ILC_WAIT_LOW;
                        end else begin
                            next_r.st = ilc_pkg::ILC_LOW;
                        end
                    end
                end
            end
            ilc_pkg::ILC_WAIT_LOW: begin
                next_r.sda_oe = 1'b0;
                next_r.cnt    = r.cnt + 16'h0001;
                if (r.cnt == 16'(WAIT_CYC - 1)) begin
                    next_r.cnt = 16'h0000;
                    next_r.st  = ilc_pkg::ILC_LOW;
                end
            end
            default: begin
                next_r.st = ilc_pkg::ILC_IDLE;
            end
        endcase
        // Only the engine is cleared, so a hung transfer recovers without reprogramming
        if (r.ctrl_rst) begin
            next_r.st      = ilc_pkg::ILC_IDLE;
            next_r.cnt     = 16'h0000;
            next_r.bitn    = 4'h0;
            next_r.scl_drv = 1'b0;
            next_r.sda_oe  = !r.level;
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            r          <= '0;
            r.st       <= ilc_pkg::ILC_IDLE;
            r.level    <= ilc_pkg::RST_LEVEL;
            r.ctrl_rst <= ilc_pkg::RST_CTRL_RST;
            r.order    <= ilc_pkg::RST_ORDER;
            r.wait_en  <= ilc_pkg::RST_WAIT;
            r.master   <= ilc_pkg::RST_MASTER;
            r.sync_fmt <= ilc_pkg::RST_SYNC_FMT;
            r.wreq     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign avs_readdata_out    = r.rdata;
    assign avs_waitrequest_out = r.wreq;
    assign scl_oe_out          = r.scl_drv;
    assign scl_out             = 1'b0;
    assign sda_oe_out          = r.sda_oe;
    assign sda_out             = 1'b0;

    // Checking helpers
    logic [15:0] low_run;
    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            low_run <= 16'h0000;
        end else begin
            low_run <= r.scl_drv ? low_run + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn);

    sequence s_line_write(logic wp);
        take_wr && avs_address_in == ilc_pkg::OFS_LINE && avs_writedata_in[ilc_pkg::LC_WP] == wp;
    endsequence
    sequence s_line_read;
        avs_read_in && r.wreq && avs_address_in == ilc_pkg::OFS_LINE;
    endsequence

    property p_level_update;
        s_line_write(1'b0) |=> r.level == $past(avs_writedata_in[ilc_pkg::LC_LEVEL]);
    endproperty
    a_level_update: assert property (p_level_update) else $error("level not updated");
    property p_level_keep;
        s_line_write(1'b1) |=> $stable(r.level);
    endproperty
    a_level_keep: assert property (p_level_keep) else $error("level changed when protected");
    property p_line_read_fixed;
        s_line_read |=> !avs_waitrequest_out && avs_readdata_out[ilc_pkg::LC_WP]
                        && avs_readdata_out[ilc_pkg::LC_RSV2] && avs_readdata_out[ilc_pkg::LC_RSV0];
    endproperty
    a_line_read_fixed: assert property (p_line_read_fixed) else $error("fixed ones wrong");
    property p_scl_monitor;
        s_line_read |=> avs_readdata_out[ilc_pkg::LC_SCL_MON] == !$past(scl_oe_out);
    endproperty
    a_scl_monitor: assert property (p_scl_monitor) else $error("clock monitor wrong");
    property p_ctrl_reset;
        r.ctrl_rst |=> r.st == ilc_pkg::ILC_IDLE && !scl_oe_out && $stable(r.order)
                       && $stable(r.wait_en);
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset failed");
    property p_wait_gap;
        $fell(r.scl_drv) && r.bitn == 4'(ilc_pkg::ACK_BIT) && wait_applies
            |-> low_run == 16'(WAIT_CYC + HALF);
    endproperty
    a_wait_gap: assert property (p_wait_gap) else $error("wait gap length wrong");
    property p_no_wait_gap;
        $fell(r.scl_drv) && r.bitn == 4'(ilc_pkg::ACK_BIT) && !r.wait_en |-> low_run == 16'(HALF);
    endproperty
    a_no_wait_gap: assert property (p_no_wait_gap) else $error("ack delayed");
    property p_sync_no_wait;
        r.sync_fmt && r.st == ilc_pkg::ILC_HIGH |=> r.st != ilc_pkg::ILC_WAIT_LOW;
    endproperty
    a_sync_no_wait: assert property (p_sync_no_wait) else $error("wait in sync format");
    property p_idle_level;
        r.st == ilc_pkg::ILC_IDLE && $stable(r.level) [*2] |-> sda_oe_out == !r.level;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("data pin not at level");
endmodule : ilc_line_ctrl

// ===== src/ilc_pkg.sv
// Constants, register map and types of the line control and mode block
package ilc_pkg;
    // Avalon byte offsets
    localparam logic [3:0] OFS_LINE   = 4'h0;
    localparam logic [3:0] OFS_MODE   = 4'h4;
    localparam logic [3:0] OFS_DATA   = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    // Line control fields
    localparam int LC_ADDR_IDLE = 7;
    localparam int LC_SCP       = 6;
    localparam int LC_LEVEL     = 5;
    localparam int LC_WP        = 4;
    localparam int LC_SCL_MON   = 3;
    localparam int LC_RSV2      = 2;
    localparam int LC_CTRL_RST  = 1;
    localparam int LC_RSV0      = 0;
    // Mode fields
    localparam int MD_ORDER     = 7;
    localparam int MD_WAIT      = 6;
    localparam int MD_MASTER    = 5;
    localparam int MD_SYNC_FMT  = 4;
    // Status fields
    localparam int ST_BUSY      = 0;
    localparam int ST_NACK      = 1;
    // Reset values
    localparam logic RST_LEVEL    = 1'b1;
    localparam logic RST_CTRL_RST = 1'b0;
    localparam logic RST_ORDER    = 1'b0;
    localparam logic RST_WAIT     = 1'b0;
    localparam logic RST_MASTER   = 1'b0;
    localparam logic RST_SYNC_FMT = 1'b0;
    // Timing
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int XFER_PERIOD_PS   = 10000000;
    localparam int HALF_CYCLES      = XFER_PERIOD_PS / CLK_PERIOD_PS / 2;
    localparam int WAIT_XFER_CLOCKS = 2;
    localparam int LAST_DATA_BIT    = 7;
    localparam int ACK_BIT          = 8;

    typedef enum logic [1:0] {
        ILC_IDLE,
        ILC_LOW,
        ILC_HIGH,
        ILC_WAIT_LOW
    } ilc_state_e;
endpackage : ilc_pkg

// ===== src/ilc_reset_sync.sv
// Reset synchroniser: asynchronous assertion, two-flop release
`timescale 1ns/1ps
module ilc_reset_sync (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    output logic      rstn_out
);
    logic stage;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage    <= 1'b0;
            rstn_out <= 1'b0;
        end else begin
            stage    <= 1'b1;
            rstn_out <= stage;
        end
    end
endmodule : ilc_reset_sync

// ===== verif/ilc_far_end.sv
// Far-end model: pull-ups on both lines and an acknowledging receiver
`timescale 1ns/1ps
module ilc_far_end (
    input  wire logic       clk_in,
    input  wire logic       clr_in,
    input  wire logic       ack_in,
    input  wire logic       scl_oe_in,
    input  wire logic       sda_oe_in,
    output logic            scl_out,
    output logic            sda_out,
    output logic [7:0]      byte_out,
    output int              rises_out,
    output int              falls_out,
    output int              span_out
);
    logic scl_q = 1'b1;
    int   cnt   = 0;
    // Released lines float up through the pull-ups
    assign scl_out = ~scl_oe_in;
    // Ack held until cleared, so the bench must clear after every frame
    assign sda_out = ~(sda_oe_in | (ack_in && falls_out == 9));
    always @(posedge clk_in) begin
        scl_q <= scl_out;
        if (clr_in) begin
            rises_out <= 0;
            falls_out <= 0;
            span_out  <= 0;
            cnt       <= 0;
            byte_out  <= 8'h00;
        end else begin
            if (!scl_out && scl_q) falls_out <= falls_out + 1;
            cnt <= (falls_out > 0 || (!scl_out && scl_q)) ? cnt + 1 : 0;
            if (scl_out && !scl_q) begin
                rises_out <= rises_out + 1;
                span_out  <= cnt;
                if (rises_out < 8) byte_out <= {byte_out[6:0], sda_out};
            end
        end
    end
endmodule : ilc_far_end

// ===== verif/ilc_line_ctrl_tb_top.sv
// Self-checking bench for the line control and mode block
`timescale 1ns/1ps
module ilc_line_ctrl_tb_top;
    localparam int H = 4;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'hf;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        scl_w, sda_w, scl_oe, sda_oe;
    logic        clr = 1'b1;
    logic        ack = 1'b0;
    logic [7:0]  q, wd, cap;
    int          rises, falls, span;
    int          err_total = 0;
    int          num_checks = 0;
    int          seed = 64979;
    int          lvl = 1;
    int          rst = 0;
    logic [7:0]  modes [5] = '{8'h20, 8'h60, 8'hb0, 8'hf0, 8'h30};

    always #2.5 clk_in = ~clk_in;

    ilc_line_ctrl #(.HALF(H)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .scl_in(scl_w), .scl_out(),
        .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe));

    ilc_far_end far (.clk_in(clk_in), .clr_in(clr), .ack_in(ack), .scl_oe_in(scl_oe),
        .sda_oe_in(sda_oe), .scl_out(scl_w), .sda_out(sda_w), .byte_out(cap),
        .rises_out(rises), .falls_out(falls), .span_out(span));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results;
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    function automatic logic [7:0] line_exp(input logic mon);
        return {1'b0, 1'b1, lvl[0], 1'b1, mon, 1'b1, rst[0], 1'b1};
    endfunction : line_exp

    // One access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be);
        @(posedge clk_in);
        avs_address_in    <= a;
        avs_writedata_in  <= {24'h0, d};
        avs_byteenable_in <= be;
        avs_write_in      <= wr;
        avs_read_in       <= !wr;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask : av

    task automatic partner_clear;
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
    endtask : partner_clear

    task automatic xfer(input logic [7:0] md, input logic [7:0] d, input logic a);
        logic [7:0] exp_b;
        exp_b = {<<{d}};
        ack <= a;
        av(1'b1, ilc_pkg::OFS_MODE, md, 4'hf);
        partner_clear();
        av(1'b1, ilc_pkg::OFS_DATA, d, 4'hf);
        do begin
            av(1'b0, ilc_pkg::OFS_STATUS, 8'h00, 4'hf);
        end while (q[ilc_pkg::ST_BUSY] !== 1'b0);
        chk(cap, md[ilc_pkg::MD_ORDER] ? exp_b : d);
        if (md[ilc_pkg::MD_SYNC_FMT]) begin
            chk(rises[15:0], 16'd8);
            chk(span[15:0], 16'(15 * H));
        end else begin
            chk(rises[15:0], 16'd9);
            chk(span[15:0], 16'(md[ilc_pkg::MD_WAIT] ? 21 * H : 17 * H));
            chk(q[ilc_pkg::ST_NACK], !a);
        end
        // Shift register reads back the byte seen on the line, in either order
        av(1'b0, ilc_pkg::OFS_DATA, 8'h00, 4'hf);
        chk(q, d);
        partner_clear();
    endtask : xfer

    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        results();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        partner_clear();
        repeat (3) @(posedge clk_in);
        av(1'b0, ilc_pkg::OFS_LINE, 8'h00, 4'hf);
        chk(q, line_exp(1'b1));
        av(1'b0, ilc_pkg::OFS_MODE, 8'h00, 4'hf);
        chk(q & 8'hf0, 8'h00);
        // First two writes fixed so a low level is always seen
        for (int i = 0; i < 12; i++) begin
            wd = (i == 0) ? 8'h10 : (i == 1) ? 8'h00 : 8'($random(seed));
            av(1'b1, ilc_pkg::OFS_LINE, wd, (i == 3) ? 4'he : 4'hf);
            if (i != 3) begin
                if (!wd[ilc_pkg::LC_WP]) lvl = wd[ilc_pkg::LC_LEVEL];
                rst = wd[ilc_pkg::LC_CTRL_RST];
            end
            av(1'b0, ilc_pkg::OFS_LINE, 8'h00, 4'hf);
            chk(q, line_exp(1'b1));
            chk(sda_oe, !lvl[0]);
            chk(sda_w, lvl[0]);
        end
        av(1'b1, ilc_pkg::OFS_LINE, 8'h20, 4'hf);
        lvl = 1;
        rst = 0;
        for (int i = 0; i < 6; i++) begin
            wd = 8'($random(seed));
            av(1'b1, ilc_pkg::OFS_MODE, wd, 4'hf);
            av(1'b0, ilc_pkg::OFS_MODE, 8'h00, 4'hf);
            chk(q, wd & 8'hf0);
        end
        av(1'b1, 4'h2, 8'hff, 4'hf);
        av(1'b0, 4'h2, 8'h00, 4'hf);
        chk(q, 8'h00);
        for (int i = 0; i < 10; i++) xfer(modes[i % 5], 8'($random(seed)), i[0]);
        // Hang a frame in the stretched ack low phase, then recover
        ack <= 1'b0;
        av(1'b1, ilc_pkg::OFS_MODE, 8'h60, 4'hf);
        av(1'b1, ilc_pkg::OFS_DATA, 8'($random(seed)), 4'hf);
        while (falls != 9) begin
            @(posedge clk_in);
        end
        av(1'b0, ilc_pkg::OFS_LINE, 8'h00, 4'hf);
        chk(q[ilc_pkg::LC_SCL_MON], 1'b0);
        av(1'b1, ilc_pkg::OFS_LINE, 8'h12, 4'hf);
        rst = 1;
        repeat (2) @(posedge clk_in);
        chk(scl_oe, 1'b0);
        av(1'b0, ilc_pkg::OFS_STATUS, 8'h00, 4'hf);
        chk(q[ilc_pkg::ST_BUSY], 1'b0);
        av(1'b0, ilc_pkg::OFS_MODE, 8'h00, 4'hf);
        chk(q & 8'hf0, 8'h60);
        av(1'b0, ilc_pkg::OFS_LINE, 8'h00, 4'hf);
        chk(q, line_exp(1'b1));
        av(1'b1, ilc_pkg::OFS_LINE, 8'h10, 4'hf);
        rst = 0;
        xfer(8'h20, 8'($random(seed)), 1'b1);
        results();
    end
endmodule : ilc_line_ctrl_tb_top
